// ---- hw/cpu_core_map.svh ----
// address map, field positions and reset values for the fetch and data space decode core
// Function
// - next instruction is fetched while the current one executes
// - one instruction completes every clock in the normal case
// - alu takes two registers, register and immediate, or one register
// - result flags register updates after each alu operation except mov and ldi
// - thirty-two eight-bit working registers, all read in one cycle
// - six registers pair into three sixteen-bit pointers for both spaces
// - program and data spaces are separate, each with its own bus
// - data decoder splits space into io, eeprom window, sram, external ram
// - all peripheral registers decode within the lowest four kilobytes
// - lowest sixty-four io addresses reachable directly and at data zero
// - extended io reachable only by data space load and store forms
// - data window 0x1000 to 0x1fff is reserved for eeprom mapping
// - first internal sram location is at data address 0x2000
// - instructions come only from program memory, never from sram
// - self program store acts only when run from the boot section
// - application, table and boot sections each have own lock bits
// - program and data addresses reach sixteen megabytes each
// - multi-byte io registers are accessed atomically at full width
// - working registers are not reachable in the data space
// - after reset fetching starts at program address zero
`ifndef CPU_CORE_MAP_SVH
`define CPU_CORE_MAP_SVH
`define IO_DIRECT_LAST 24'h00003f
`define IO_SPACE_LAST 24'h000fff
`define EEP_WIN_FIRST 24'h001000
`define EEP_WIN_LAST 24'h001fff
`define SRAM_FIRST 24'h002000
`define RESET_PC 23'h000000
`define PTR_X_LO 5'h1a
`define PTR_Y_LO 5'h1c
`define PTR_Z_LO 5'h1e
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAGS_RESET 8'h00
`endif

// ---- hw/cpu_core_pkg.sv ----
// types for the fetch and data space decode core
package cpu_core_pkg;
   typedef enum logic [2:0] {REGION_IO, REGION_EEP, REGION_SRAM, REGION_EXT} region_t;
   typedef enum logic [3:0] {
      OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV,
      OP_LDI, OP_SUBI, OP_INC, OP_DEC, OP_COM, OP_LOAD, OP_STORE, OP_SPM
   } op_t;
   typedef enum logic [1:0] {AM_DIRECT_IO, AM_DATA_ABS, AM_DATA_PTR} amode_t;
   typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_t;
   // one decoded instruction word
   typedef struct packed {
      op_t op;
      amode_t amode;
      ptr_t ptr;
      logic [4:0] rd;
      logic [4:0] rr;
      logic [7:0] imm;
      logic [23:0] addr;
      logic wide;
   } instr_t;
   // one data bus request
   typedef struct packed {
      logic req;
      logic we;
      logic wide;
      region_t region;
      logic [23:0] addr;
      logic [15:0] wdata;
   } dreq_t;
   // one self program request
   typedef struct packed {
      logic req;
      logic [22:0] addr;
      logic [15:0] wdata;
   } spm_t;
endpackage

// ---- hw/cpu_fetch_decode.sv ----
// fetch and execute core with data space decoder and flash section protection
`timescale 1ns/1ps
`include "cpu_core_map.svh"
module cpu_fetch_decode #(
   parameter int unsigned PADDR_W = 23,
   parameter int unsigned DADDR_W = 24,
   parameter logic [22:0] BOOT_START = 23'h010000,
   parameter logic [22:0] TABLE_START = 23'h00f000
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire cpu_core_pkg::instr_t progData,
   input wire logic progValid,
   input wire logic [15:0] dataRdata,
   input wire logic dataReady,
   input wire logic [5:0] lockBits,
   output logic [22:0] progAddr,
   output logic progRd,
   output cpu_core_pkg::dreq_t dataReq,
   output cpu_core_pkg::spm_t spmReq,
   output logic [7:0] flags,
   output logic accessFault
);
   // address widths beyond sixteen megabytes cannot be served
   if (PADDR_W != 23 || DADDR_W != 24 || BOOT_START <= TABLE_START) begin : g_bad_layout
      $error("cpu_fetch_decode: unsupported address widths or section layout");
   end

   logic [7:0] regFile[32];
   logic [22:0] pc_ff;
   logic [22:0] execPc_ff;
   cpu_core_pkg::instr_t ir_ff;
   logic irValid_ff;
   logic stall;
   logic [7:0] opA;
   logic [7:0] opB;
   logic [8:0] aluRes;
   logic aluWr;
   logic [7:0] nxt_flags;
   logic [15:0] ptrVal;
   logic [23:0] effAddr;
   cpu_core_pkg::region_t effRegion;
   logic memOp;
   logic memFault;
   logic inBoot;
   logic spmOk;
   logic dataPend_ff;
   logic dataIssue;

   localparam logic [23:0] SRAM_BYTES = 24'h004000;

   // regions of the linear data space
   function automatic cpu_core_pkg::region_t region_of(input logic [23:0] a);
      if (a <= `IO_SPACE_LAST) begin
         region_of = cpu_core_pkg::REGION_IO;
      end else if (a >= `EEP_WIN_FIRST && a <= `EEP_WIN_LAST) begin
         region_of = cpu_core_pkg::REGION_EEP;
      end else if (a >= `SRAM_FIRST && a < `SRAM_FIRST + SRAM_BYTES) begin
         region_of = cpu_core_pkg::REGION_SRAM;
      end else begin
         region_of = cpu_core_pkg::REGION_EXT;
      end
   endfunction

   // pointer pair read from two working registers
   function automatic logic [15:0] pair_of(input logic [4:0] lo, input logic [7:0] rf[32]);
      pair_of = {rf[lo + 5'h01], rf[lo]};
   endfunction

   // a data access waits for the data bus unless it faults; everything else runs every cycle
   assign memOp = irValid_ff && (ir_ff.op == cpu_core_pkg::OP_LOAD ||
                                 ir_ff.op == cpu_core_pkg::OP_STORE);
   assign stall = memOp && !memFault && !dataReady;
   // a request goes out once per access; the pending flag blocks a repeat
   assign dataIssue = memOp && !memFault && !dataPend_ff && !dataReady;

   // program counter and prefetch of the next word during execution
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pc_ff <= `RESET_PC;
         ir_ff <= '0;
         irValid_ff <= 1'b0;
         execPc_ff <= `RESET_PC;
      end else if (!stall) begin
         ir_ff <= progData;
         irValid_ff <= progValid;
         execPc_ff <= pc_ff;
         if (progValid) begin
            pc_ff <= pc_ff + 23'h000001;
         end
      end
   end

   // the program bus address is the fetch counter itself
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         progAddr <= `RESET_PC;
         progRd <= 1'b0;
      end else begin
         progAddr <= (!stall && progValid) ? pc_ff + 23'h000001 : pc_ff;
         progRd <= 1'b1;
      end
   end

   // operand selection: two registers, register and immediate, or one register
   always_comb begin
      opA = regFile[ir_ff.rd];
      unique case (ir_ff.op)
         cpu_core_pkg::OP_LDI, cpu_core_pkg::OP_SUBI: opB = ir_ff.imm;
         cpu_core_pkg::OP_INC, cpu_core_pkg::OP_DEC: opB = 8'h01;
         default: opB = regFile[ir_ff.rr];
      endcase
   end

   // alu proper
   always_comb begin
      aluWr = irValid_ff;
      unique case (ir_ff.op)
         cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_INC: aluRes = {1'b0, opA} + {1'b0, opB};
         cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SUBI, cpu_core_pkg::OP_DEC:
            aluRes = {1'b0, opA} - {1'b0, opB};
         cpu_core_pkg::OP_AND: aluRes = {1'b0, opA & opB};
         cpu_core_pkg::OP_OR: aluRes = {1'b0, opA | opB};
         cpu_core_pkg::OP_XOR: aluRes = {1'b0, opA ^ opB};
         cpu_core_pkg::OP_COM: aluRes = {1'b1, ~opA};
         cpu_core_pkg::OP_MOV, cpu_core_pkg::OP_LDI: aluRes = {1'b0, opB};
         default: begin
            aluRes = 9'h000;
            aluWr = 1'b0;
         end
      endcase
   end

   // result flags follow each arithmetic or logic result
   always_comb begin
      nxt_flags = flags;
      if (aluWr && ir_ff.op != cpu_core_pkg::OP_MOV && ir_ff.op != cpu_core_pkg::OP_LDI) begin
         nxt_flags[`FLAG_Z] = (aluRes[7:0] == 8'h00);
         nxt_flags[`FLAG_N] = aluRes[7];
         if (ir_ff.op != cpu_core_pkg::OP_INC && ir_ff.op != cpu_core_pkg::OP_DEC) begin
            nxt_flags[`FLAG_C] = aluRes[8];
         end
         unique case (ir_ff.op)
            cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_INC:
               nxt_flags[`FLAG_V] = (opA[7] == opB[7]) && (aluRes[7] != opA[7]);
            cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SUBI, cpu_core_pkg::OP_DEC:
               nxt_flags[`FLAG_V] = (opA[7] != opB[7]) && (aluRes[7] != opA[7]);
            default: nxt_flags[`FLAG_V] = 1'b0;
         endcase
         nxt_flags[`FLAG_S] = nxt_flags[`FLAG_N] ^ nxt_flags[`FLAG_V];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= `FLAGS_RESET;
      end else if (!stall) begin
         flags <= nxt_flags;
      end
   end

   // register file write back: alu results and one- or two-byte loads
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) begin
            regFile[i] <= 8'h00;
         end
      end else if (aluWr && !stall) begin
         regFile[ir_ff.rd] <= aluRes[7:0];
      end else if (memOp && dataReady && ir_ff.op == cpu_core_pkg::OP_LOAD && !memFault) begin
         regFile[ir_ff.rd] <= dataRdata[7:0];
         if (ir_ff.wide) begin
            regFile[ir_ff.rd + 5'h01] <= dataRdata[15:8];
         end
      end
   end

   // effective data address from an absolute field or a pointer pair
   always_comb begin
      unique case (ir_ff.ptr)
         cpu_core_pkg::PTR_X: ptrVal = pair_of(`PTR_X_LO, regFile);
         cpu_core_pkg::PTR_Y: ptrVal = pair_of(`PTR_Y_LO, regFile);
         default: ptrVal = pair_of(`PTR_Z_LO, regFile);
      endcase
      unique case (ir_ff.amode)
         cpu_core_pkg::AM_DIRECT_IO: effAddr = {18'h00000, ir_ff.addr[5:0]};
         cpu_core_pkg::AM_DATA_PTR: effAddr = {8'h00, ptrVal};
         default: effAddr = ir_ff.addr;
      endcase
      effRegion = region_of(effAddr);
      // direct io form may never reach beyond the lowest sixty-four addresses
      memFault = (ir_ff.amode == cpu_core_pkg::AM_DIRECT_IO) &&
                 (ir_ff.addr > `IO_DIRECT_LAST);
   end

   // data bus request; working registers never appear here
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dataReq <= '0;
      end else begin
         dataReq.req <= dataIssue;
         dataReq.we <= ir_ff.op == cpu_core_pkg::OP_STORE;
         dataReq.wide <= ir_ff.wide;
         dataReq.region <= effRegion;
         dataReq.addr <= effAddr;
         dataReq.wdata <= {regFile[ir_ff.rd + 5'h01], regFile[ir_ff.rd]};
      end
   end

   // access outstanding on the data bus until the ready answer arrives
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dataPend_ff <= 1'b0;
      end else if (dataReady) begin
         dataPend_ff <= 1'b0;
      end else if (dataIssue) begin
         dataPend_ff <= 1'b1;
      end
   end

   // section decode and lock bits: [1:0] application, [3:2] table, [5:4] boot
   assign inBoot = execPc_ff >= BOOT_START;
   always_comb begin
      spmOk = inBoot;
      if (ptrVal[15:1] >= TABLE_START[14:0] && {8'h00, ptrVal[15:1]} < BOOT_START) begin
         spmOk = spmOk && !lockBits[2];
      end else if ({8'h00, ptrVal[15:1]} >= BOOT_START) begin
         spmOk = spmOk && !lockBits[4];
      end else begin
         spmOk = spmOk && !lockBits[0];
      end
   end

   // self program store requests and access faults
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         spmReq <= '0;
         accessFault <= 1'b0;
      end else begin
         spmReq.req <= irValid_ff && !stall && ir_ff.op == cpu_core_pkg::OP_SPM && spmOk;
         spmReq.addr <= {8'h00, ptrVal[15:1]};
         spmReq.wdata <= {regFile[5'h01], regFile[5'h00]};
         accessFault <= irValid_ff && !stall &&
                        ((ir_ff.op == cpu_core_pkg::OP_SPM && !spmOk) || (memOp && memFault));
      end
   end

   // reset value of the fetch counter
   property p_reset_pc;
      @(posedge mclk) $rose(rst_n) |-> pc_ff == `RESET_PC;
   endproperty
   a_reset_pc: assert property (p_reset_pc) else $error("fetch did not start at zero");

   // without data stall the fetch counter advances every cycle
   property p_fetch_advance;
      @(posedge mclk) disable iff (!rst_n) (!stall && progValid) |=> pc_ff == $past(pc_ff) + 23'h1;
   endproperty
   a_fetch_advance: assert property (p_fetch_advance) else $error("fetch did not overlap");

   // stall holds the executing word
   property p_stall_hold;
      @(posedge mclk) disable iff (!rst_n) stall |=> $stable(execPc_ff);
   endproperty
   a_stall_hold: assert property (p_stall_hold) else $error("stalled instruction moved");

   // zero flag matches the last add result
   property p_zero_flag;
      @(posedge mclk) disable iff (!rst_n)
         (!stall && aluWr && ir_ff.op == cpu_core_pkg::OP_ADD) |=> flags[`FLAG_Z] == ($past(aluRes[7:0]) == 8'h00);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

   // eeprom window decode
   property p_eep_window;
      @(posedge mclk) disable iff (!rst_n)
         dataReq.req && dataReq.addr >= `EEP_WIN_FIRST && dataReq.addr <= `EEP_WIN_LAST
         |-> dataReq.region == cpu_core_pkg::REGION_EEP;
   endproperty
   a_eep_window: assert property (p_eep_window) else $error("eeprom window misdecoded");

   // io decode below four kilobytes
   property p_io_space;
      @(posedge mclk) disable iff (!rst_n)
         dataReq.req && dataReq.addr <= `IO_SPACE_LAST |-> dataReq.region == cpu_core_pkg::REGION_IO;
   endproperty
   a_io_space: assert property (p_io_space) else $error("io space misdecoded");

   // sram starts at its first address
   property p_sram_start;
      @(posedge mclk) disable iff (!rst_n)
         dataReq.req && dataReq.region == cpu_core_pkg::REGION_SRAM |-> dataReq.addr >= `SRAM_FIRST;
   endproperty
   a_sram_start: assert property (p_sram_start) else $error("sram below first address");

   // self program store only from the boot section
   property p_spm_boot;
      @(posedge mclk) disable iff (!rst_n) spmReq.req |-> $past(execPc_ff) >= BOOT_START;
   endproperty
   a_spm_boot: assert property (p_spm_boot) else $error("store issued outside boot");

   // direct io form never issues an extended io access
   property p_direct_io;
      @(posedge mclk) disable iff (!rst_n)
         (memOp && ir_ff.amode == cpu_core_pkg::AM_DIRECT_IO && ir_ff.addr > `IO_DIRECT_LAST)
         |=> !dataReq.req && accessFault;
   endproperty
   a_direct_io: assert property (p_direct_io) else $error("extended io reached directly");

   // one request per access, never repeated while the answer is awaited
   property p_req_once;
      @(posedge mclk) disable iff (!rst_n) dataReq.req |=> !dataReq.req;
   endproperty
   a_req_once: assert property (p_req_once) else $error("data request repeated");

   // a waiting access reaches the data bus at the next edge
   property p_req_issue;
      @(posedge mclk) disable iff (!rst_n)
         (memOp && !memFault && !dataPend_ff && !dataReady) |=> dataReq.req;
   endproperty
   a_req_issue: assert property (p_req_issue) else $error("data request not issued");

   // internal sram decode
   property p_sram_region;
      @(posedge mclk) disable iff (!rst_n)
         dataReq.req && dataReq.addr >= `SRAM_FIRST &&
         dataReq.addr < `SRAM_FIRST + SRAM_BYTES |-> dataReq.region == cpu_core_pkg::REGION_SRAM;
   endproperty
   a_sram_region: assert property (p_sram_region) else $error("sram misdecoded");

   // everything above the sram goes to the external interface
   property p_ext_region;
      @(posedge mclk) disable iff (!rst_n)
         dataReq.req && dataReq.addr >= `SRAM_FIRST + SRAM_BYTES
         |-> dataReq.region == cpu_core_pkg::REGION_EXT;
   endproperty
   a_ext_region: assert property (p_ext_region) else $error("external ram misdecoded");

   // a refused store-program raises the fault and sends nothing
   property p_spm_refused;
      @(posedge mclk) disable iff (!rst_n)
         (irValid_ff && !stall && ir_ff.op == cpu_core_pkg::OP_SPM && !spmOk)
         |=> accessFault && !spmReq.req;
   endproperty
   a_spm_refused: assert property (p_spm_refused) else $error("locked store not refused");

   // a faulting direct io access never waits for the data bus
   property p_fault_no_wait;
      @(posedge mclk) disable iff (!rst_n) (memOp && memFault) |-> !stall;
   endproperty
   a_fault_no_wait: assert property (p_fault_no_wait) else $error("refused access stalled");
endmodule // cpu_fetch_decode

// ---- test/cpu_fetch_and_data_space_decode_bench.sv ----
// self-checking bench for the fetch and data space decode core
`timescale 1ns/1ps
`include "cpu_core_map.svh"
module cpu_fetch_and_data_space_decode_bench;
   localparam logic [22:0] BOOT_AT = 23'h000040;
   logic mclk;
   logic rst_n;
   logic [5:0] lockBits;
   cpu_core_pkg::instr_t progData;
   logic progValid;
   logic [15:0] dataRdata;
   logic dataReady;
   logic [22:0] progAddr;
   logic progRd;
   cpu_core_pkg::dreq_t dataReq;
   cpu_core_pkg::spm_t spmReq;
   cpu_core_pkg::spm_t lastSpm;
   logic [7:0] flags;
   logic accessFault;
   int mismatches = 0;
   int total_checks = 0;
   int faults = 0;
   int spmCount = 0;
   int r0;
   int f0;
   int s0;
   cpu_fetch_decode #(.BOOT_START(BOOT_AT), .TABLE_START(23'h000020)) dut (
      .mclk(mclk), .rst_n(rst_n), .progData(progData), .progValid(progValid),
      .dataRdata(dataRdata), .dataReady(dataReady), .lockBits(lockBits),
      .progAddr(progAddr), .progRd(progRd), .dataReq(dataReq), .spmReq(spmReq),
      .flags(flags), .accessFault(accessFault));
   cpu_mem_model pm (
      .mclk(mclk), .rst_n(rst_n), .progAddr(progAddr), .progRd(progRd), .dataReq(dataReq),
      .progData(progData), .progValid(progValid), .dataRdata(dataRdata),
      .dataReady(dataReady));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // count refusals and program store pulses
   always @(posedge mclk) begin
      if (accessFault === 1'b1) faults++;
      if (spmReq.req === 1'b1) begin
         spmCount++;
         lastSpm = spmReq;
      end
   end
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic cpu_core_pkg::instr_t mk(input cpu_core_pkg::op_t op,
      input logic [4:0] rd, input logic [7:0] imm, input logic [23:0] a = 24'h000000,
      input cpu_core_pkg::amode_t am = cpu_core_pkg::AM_DATA_ABS);
      mk = '{op, am, cpu_core_pkg::PTR_Z, rd, rd + 5'h01, imm, a, 1'b0};
   endfunction
   task automatic clear_rom();
      for (int i = 0; i < 128; i++) pm.rom[i] = mk(cpu_core_pkg::OP_NOP, 5'h00, 8'h00);
   endtask
   // reset pulse, take baselines, then run n cycles
   task automatic restart(input int n);
      @(posedge mclk) #1 rst_n = 1'b0;
      @(posedge mclk) #1 rst_n = 1'b1;
      r0 = pm.reqCount;
      f0 = faults;
      s0 = spmCount;
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic test_reset();
      clear_rom();
      @(posedge mclk) #1 rst_n = 1'b0;
      @(posedge mclk) #1;
      chk(progRd, 1'b0);
      chk(flags, `FLAGS_RESET);
      rst_n = 1'b1;
      @(posedge mclk) #1;
      chk(progRd, 1'b1);
      chk(progAddr, `RESET_PC);
      repeat (10) @(posedge mclk);
      #1;
      chk(progAddr, 23'h00000a);
      $display("test reset and fetch done");
   endtask
   task automatic test_alu();
      clear_rom();
      pm.rom[0] = mk(cpu_core_pkg::OP_LDI, 5'h10, 8'h05);
      pm.rom[1] = mk(cpu_core_pkg::OP_LDI, 5'h11, 8'h03);
      pm.rom[2] = mk(cpu_core_pkg::OP_ADD, 5'h10, 8'h00);
      pm.rom[3] = mk(cpu_core_pkg::OP_STORE, 5'h10, 8'h00, 24'h002000);
      pm.rom[4] = mk(cpu_core_pkg::OP_SUBI, 5'h10, 8'h08);
      pm.rom[5] = mk(cpu_core_pkg::OP_STORE, 5'h10, 8'h00, 24'h002002);
      pm.rom[5].wide = 1'b1;
      restart(30);
      chk(pm.ram[8'h00], 8'h08);
      chk(flags[`FLAG_Z], 1'b1);
      chk(flags[`FLAG_C], 1'b0);
      chk(pm.lastReq.wdata, 16'h0300);
      chk(pm.lastReq.wide, 1'b1);
      $display("test alu done");
   endtask
   task automatic test_decode();
      logic [23:0] adr [10] = '{24'h000040, 24'h000fff, 24'h001000, 24'h001fff, 24'h002000,
         24'h005fff, 24'h006000, 24'hffffff, 24'h00003f, 24'h000040};
      cpu_core_pkg::region_t rgn [10] = '{cpu_core_pkg::REGION_IO, cpu_core_pkg::REGION_IO,
         cpu_core_pkg::REGION_EEP, cpu_core_pkg::REGION_EEP, cpu_core_pkg::REGION_SRAM,
         cpu_core_pkg::REGION_SRAM, cpu_core_pkg::REGION_EXT, cpu_core_pkg::REGION_EXT,
         cpu_core_pkg::REGION_IO, cpu_core_pkg::REGION_IO};
      for (int i = 0; i < 10; i++) begin
         clear_rom();
         pm.rom[0] = mk(cpu_core_pkg::OP_STORE, 5'h00, 8'h00, adr[i],
            i > 7 ? cpu_core_pkg::AM_DIRECT_IO : cpu_core_pkg::AM_DATA_ABS);
         restart(12);
         chk(24'(faults - f0), i == 9 ? 24'h000001 : 24'h000000);
         chk(24'(pm.reqCount - r0), i == 9 ? 24'h000000 : 24'h000001);
         if (i < 9) begin
            chk(pm.lastReq.addr, adr[i]);
            chk(pm.lastReq.region, rgn[i]);
         end
      end
      $display("test decode done");
   endtask
   task automatic test_load();
      clear_rom();
      pm.ram[8'h04] = 8'h5a;
      pm.ram[8'h05] = 8'h00;
      pm.lat = 3;
      pm.rom[0] = mk(cpu_core_pkg::OP_LOAD, 5'h14, 8'h00, 24'h002004);
      pm.rom[1] = mk(cpu_core_pkg::OP_STORE, 5'h14, 8'h00, 24'h002006);
      restart(30);
      chk(pm.ram[8'h06], 8'h5a);
      chk(24'(pm.reqCount - r0), 24'h000002);
      pm.lat = 0;
      $display("test load stall done");
   endtask
   task automatic test_spm();
      for (int k = 0; k < 3; k++) begin
         clear_rom();
         pm.rom[0] = mk(cpu_core_pkg::OP_LDI, 5'h1e, 8'h10);
         pm.rom[1] = mk(cpu_core_pkg::OP_LDI, 5'h1f, 8'h00);
         pm.rom[2] = mk(cpu_core_pkg::OP_LDI, 5'h00, 8'hcd);
         pm.rom[3] = mk(cpu_core_pkg::OP_LDI, 5'h01, 8'hab);
         pm.rom[4] = mk(cpu_core_pkg::OP_STORE, 5'h00, 8'h00, 24'h0, cpu_core_pkg::AM_DATA_PTR);
         pm.rom[5] = mk(cpu_core_pkg::OP_SPM, 5'h00, 8'h00);
         pm.rom[BOOT_AT[6:0]] = mk(cpu_core_pkg::OP_SPM, 5'h00, 8'h00);
         // pass two locks the application, pass three only the table section
         lockBits = k == 1 ? 6'h01 : (k == 2 ? 6'h04 : 6'h00);
         restart(80);
         chk(pm.lastReq.addr, 24'h000010);
         chk(24'(faults - f0), k == 1 ? 24'h000002 : 24'h000001);
         chk(24'(spmCount - s0), k == 1 ? 24'h000000 : 24'h000001);
         if (k != 1) chk(lastSpm.wdata, 16'habcd);
         if (k != 1) chk(lastSpm.addr, 23'h000008);
      end
      lockBits = 6'h00;
      $display("test self program done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #100000;
      mismatches++;
      $display("watchdog expired");
      end_of_test();
   end
   initial begin
      rst_n = 1'b0;
      lockBits = 6'h00;
      repeat (16) @(posedge mclk);
      #1 rst_n = 1'b1;
      test_reset();
      test_alu();
      test_decode();
      test_load();
      test_spm();
      end_of_test();
   end
endmodule // cpu_fetch_and_data_space_decode_bench

// ---- test/cpu_mem_model.sv ----
// program and data memory model facing the fetch and decode core
`timescale 1ns/1ps
module cpu_mem_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [22:0] progAddr,
   input wire logic progRd,
   input wire cpu_core_pkg::dreq_t dataReq,
   output cpu_core_pkg::instr_t progData,
   output logic progValid,
   output logic [15:0] dataRdata,
   output logic dataReady
);
   cpu_core_pkg::instr_t rom [0:127];
   logic [7:0] ram [0:255];
   cpu_core_pkg::dreq_t lastReq;
   int reqCount = 0;
   int lat = 0;
   int waitCnt = 0;
   logic busy = 1'b0;
   // words come from the program store only, on a bus of its own
   assign progData = rom[progAddr[6:0]];
   assign progValid = progRd;
   initial begin
      dataRdata = 16'h0000;
      dataReady = 1'b0;
   end
   // data side takes a request and answers after lat idle cycles
   always @(posedge mclk) begin
      dataReady <= 1'b0;
      dataRdata <= ~dataRdata; // idle bus never holds the old value
      if (!rst_n) begin
         busy <= 1'b0;
      end else if (dataReq.req === 1'b1) begin
         lastReq <= dataReq;
         reqCount <= reqCount + 1;
         busy <= 1'b1;
         waitCnt <= lat;
         if (dataReq.we) begin
            ram[dataReq.addr[7:0]] <= dataReq.wdata[7:0];
            if (dataReq.wide) ram[dataReq.addr[7:0] + 8'h01] <= dataReq.wdata[15:8];
         end
      end else if (busy && waitCnt == 0) begin
         dataReady <= 1'b1;
         dataRdata <= {ram[lastReq.addr[7:0] + 8'h01], ram[lastReq.addr[7:0]]};
         busy <= 1'b0;
      end else if (busy) begin
         waitCnt <= waitCnt - 1;
      end
   end
endmodule // cpu_mem_model
